// ==== himl_regs.vh ====
// register map, field positions and reset values of the interrupt mask logic
// ==========================================================================
// Function
// - a set main mask bit lets its event raise the processor interrupt
// - main mask changes only by writing ones at its set or clear address
// - mask bit 31 is a global gate; at zero no interrupt is driven
// - reading the main event clear address returns events ANDed with mask
// - any reset clears the global gate; other mask bits may be anything
// - main mask uses the event bit layout; reserved bits stay zero
// - iso event and mask registers: written ones set or clear, zeros do nothing
// - transmit summary event is set while transmit events AND mask is nonzero
// - receive summary event is set while receive events AND mask is nonzero
// - event set address reads raw bits, clear address reads masked bits
// - transmit context event sets when its last descriptor completes with field 11
// - receive context event sets when its last descriptor completes with field 11
// - mask bits of unimplemented contexts always read zero
// - after reset iso registers may hold anything; the cleared gate blocks interrupts
// - receive summary sits at bit 7, combinational, not latched
`ifndef HIML_REGS_VH
`define HIML_REGS_VH

// ==========================================================================
// register offsets (byte addresses, compared against haddr[11:0])
`define HIML_OFS_MAIN_EVT_SET  12'h000
`define HIML_OFS_MAIN_EVT_CLR  12'h004
`define HIML_OFS_MASK_SET      12'h008
`define HIML_OFS_MASK_CLR      12'h00C
`define HIML_OFS_TX_EVT_SET    12'h010
`define HIML_OFS_TX_EVT_CLR    12'h014
`define HIML_OFS_TX_MSK_SET    12'h018
`define HIML_OFS_TX_MSK_CLR    12'h01C
`define HIML_OFS_RX_EVT_SET    12'h020
`define HIML_OFS_RX_EVT_CLR    12'h024
`define HIML_OFS_RX_MSK_SET    12'h028
`define HIML_OFS_RX_MSK_CLR    12'h02C
`define HIML_OFS_LSB           0
`define HIML_OFS_MSB           11

// ==========================================================================
// field positions and layouts
`define HIML_GATE_BIT          31
`define HIML_TX_SUM_BIT        6
`define HIML_RX_SUM_BIT        7
`define HIML_MAIN_EVT_VALID    32'h47FB03FF
`define HIML_MAIN_MASK_VALID   32'hC7FB03FF
`define HIML_SUM_BITS          32'h000000C0
`define HIML_INT_ALWAYS        2'h3
`define HIML_HTRANS_NONSEQ_BIT 1

// ==========================================================================
// reset values and defaults
`define HIML_ZERO32            32'h00000000
`define HIML_MASK_RST          32'h00000000
`define HIML_ISO_RST           32'h00000000
`define HIML_TX_IMPL_DEF       32'h000000FF
`define HIML_RX_IMPL_DEF       32'h000000FF

`endif

// ==== himl_top.v ====
// interrupt masking and aggregation with an AHB-Lite register slave
`timescale 1ns/10ps
`include "himl_regs.vh"

module himl_top #(
  parameter [31:0] TX_IMPL = `HIML_TX_IMPL_DEF,
  parameter [31:0] RX_IMPL = `HIML_RX_IMPL_DEF
) (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // main event sources, levels
  input  wire [31:0] main_event_src,
  // per-context descriptor completion
  input  wire [31:0] tx_last_done,
  input  wire [63:0] tx_int_ctrl,
  input  wire [31:0] rx_last_done,
  input  wire [63:0] rx_int_ctrl,
  // interrupt and summaries
  output wire        irq,
  output wire        iso_transmit_summary,
  output wire        iso_receive_summary
);

  // ========================================================================
  // data-phase sequencer
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WR   = 4'b0010;
  localparam [3:0] ST_RD1  = 4'b0100;
  localparam [3:0] ST_RD2  = 4'b1000;

  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [11:0] dp_addr;
  wire        accept;

  assign accept    = hsel & hready & htrans[`HIML_HTRANS_NONSEQ_BIT];
  // reads take one wait state so that hrdata comes from a flip-flop
  assign hreadyout = ~(state == ST_RD1);
  assign hresp     = 1'b0;

  always @* begin
    next_state = ST_IDLE;
    case (state)
      ST_RD1: begin
        next_state = ST_RD2;
      end
      ST_IDLE, ST_WR, ST_RD2: begin
        if (accept) begin
          next_state = hwrite ? ST_WR : ST_RD1;
        end else begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= ST_IDLE;
      dp_addr <= 12'h000;
    end else begin
      state <= next_state;
      if (accept) begin
        dp_addr <= haddr[`HIML_OFS_MSB:`HIML_OFS_LSB];
      end
    end
  end

  // ========================================================================
  // write strobes, one per writable address; none for the two main event addresses
  wire wr;
  assign wr = (state == ST_WR);

  wire wr_mask_set;
  wire wr_mask_clr;
  wire wr_txe_set;
  wire wr_txe_clr;
  wire wr_txm_set;
  wire wr_txm_clr;
  wire wr_rxe_set;
  wire wr_rxe_clr;
  wire wr_rxm_set;
  wire wr_rxm_clr;

  assign wr_mask_set = wr & (dp_addr == `HIML_OFS_MASK_SET);
  assign wr_mask_clr = wr & (dp_addr == `HIML_OFS_MASK_CLR);
  assign wr_txe_set  = wr & (dp_addr == `HIML_OFS_TX_EVT_SET);
  assign wr_txe_clr  = wr & (dp_addr == `HIML_OFS_TX_EVT_CLR);
  assign wr_txm_set  = wr & (dp_addr == `HIML_OFS_TX_MSK_SET);
  assign wr_txm_clr  = wr & (dp_addr == `HIML_OFS_TX_MSK_CLR);
  assign wr_rxe_set  = wr & (dp_addr == `HIML_OFS_RX_EVT_SET);
  assign wr_rxe_clr  = wr & (dp_addr == `HIML_OFS_RX_EVT_CLR);
  assign wr_rxm_set  = wr & (dp_addr == `HIML_OFS_RX_MSK_SET);
  assign wr_rxm_clr  = wr & (dp_addr == `HIML_OFS_RX_MSK_CLR);

  // ones written at the set address set, at the clear address clear
  function [31:0] set_clr;
    input [31:0] cur;
    input [31:0] data;
    input        do_set;
    input        do_clr;
    begin
      set_clr = cur;
      if (do_set) begin
        set_clr = cur | data;
      end
      if (do_clr) begin
        set_clr = cur & ~data;
      end
    end
  endfunction

  // ========================================================================
  // per-context completion events
  wire [31:0] tx_hit;
  wire [31:0] rx_hit;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_ctx
      assign tx_hit[gi] = tx_last_done[gi] & (tx_int_ctrl[2*gi+1:2*gi] == `HIML_INT_ALWAYS);
      assign rx_hit[gi] = rx_last_done[gi] & (rx_int_ctrl[2*gi+1:2*gi] == `HIML_INT_ALWAYS);
    end
  endgenerate

  // ========================================================================
  // registers
  reg  [31:0] interrupt_enable_mask;
  reg  [31:0] iso_transmit_event_flags;
  reg  [31:0] iso_transmit_event_enable;
  reg  [31:0] iso_receive_event_flags;
  reg  [31:0] iso_receive_event_enable;

  wire [31:0] next_mask;
  wire [31:0] next_tx_evt;
  wire [31:0] next_tx_msk;
  wire [31:0] next_rx_evt;
  wire [31:0] next_rx_msk;

  assign next_mask   = set_clr(interrupt_enable_mask, hwdata, wr_mask_set, wr_mask_clr)
                       & `HIML_MAIN_MASK_VALID;
  // hardware set wins over a software clear in the same cycle
  assign next_tx_evt = (set_clr(iso_transmit_event_flags, hwdata, wr_txe_set, wr_txe_clr)
                       | tx_hit) & TX_IMPL;
  assign next_rx_evt = (set_clr(iso_receive_event_flags, hwdata, wr_rxe_set, wr_rxe_clr)
                       | rx_hit) & RX_IMPL;
  assign next_tx_msk = set_clr(iso_transmit_event_enable, hwdata, wr_txm_set, wr_txm_clr)
                       & TX_IMPL;
  assign next_rx_msk = set_clr(iso_receive_event_enable, hwdata, wr_rxm_set, wr_rxm_clr)
                       & RX_IMPL;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_enable_mask     <= `HIML_MASK_RST;
      iso_transmit_event_flags  <= `HIML_ISO_RST;
      iso_transmit_event_enable <= `HIML_ISO_RST;
      iso_receive_event_flags   <= `HIML_ISO_RST;
      iso_receive_event_enable  <= `HIML_ISO_RST;
    end else begin
      interrupt_enable_mask     <= next_mask;
      iso_transmit_event_flags  <= next_tx_evt;
      iso_transmit_event_enable <= next_tx_msk;
      iso_receive_event_flags   <= next_rx_evt;
      iso_receive_event_enable  <= next_rx_msk;
    end
  end

  // ========================================================================
  // summaries and main event aggregation
  wire [31:0] tx_masked;
  wire [31:0] rx_masked;
  wire [31:0] main_event_flags;
  wire [31:0] main_masked;
  wire        global_interrupt_gate;

  assign tx_masked            = iso_transmit_event_flags & iso_transmit_event_enable;
  assign rx_masked            = iso_receive_event_flags & iso_receive_event_enable;
  assign iso_transmit_summary = |tx_masked;
  assign iso_receive_summary  = |rx_masked;

  // summary bits are not latched; they follow the context registers
  assign main_event_flags = ((main_event_src & ~`HIML_SUM_BITS)
                            | ({31'h00000000, iso_transmit_summary} << `HIML_TX_SUM_BIT)
                            | ({31'h00000000, iso_receive_summary} << `HIML_RX_SUM_BIT))
                            & `HIML_MAIN_EVT_VALID;

  assign main_masked           = main_event_flags & interrupt_enable_mask;
  assign global_interrupt_gate = interrupt_enable_mask[`HIML_GATE_BIT];
  assign irq                   = global_interrupt_gate & (|main_masked);

  // ========================================================================
  // read path
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = `HIML_ZERO32;
    case (dp_addr)
      `HIML_OFS_MAIN_EVT_SET: rd_mux = main_event_flags;
      `HIML_OFS_MAIN_EVT_CLR: rd_mux = main_masked;
      `HIML_OFS_MASK_SET:     rd_mux = interrupt_enable_mask;
      `HIML_OFS_MASK_CLR:     rd_mux = interrupt_enable_mask;
      `HIML_OFS_TX_EVT_SET:   rd_mux = iso_transmit_event_flags;
      `HIML_OFS_TX_EVT_CLR:   rd_mux = tx_masked;
      `HIML_OFS_TX_MSK_SET:   rd_mux = iso_transmit_event_enable;
      `HIML_OFS_TX_MSK_CLR:   rd_mux = iso_transmit_event_enable;
      `HIML_OFS_RX_EVT_SET:   rd_mux = iso_receive_event_flags;
      `HIML_OFS_RX_EVT_CLR:   rd_mux = rx_masked;
      `HIML_OFS_RX_MSK_SET:   rd_mux = iso_receive_event_enable;
      `HIML_OFS_RX_MSK_CLR:   rd_mux = iso_receive_event_enable;
      default:                rd_mux = `HIML_ZERO32;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `HIML_ZERO32;
    end else if (state == ST_RD1) begin
      hrdata <= rd_mux;
    end
  end

endmodule

// ==== himl_top_assertions.sv ====
// bus timing and interrupt output checks for himl_top
`timescale 1ns/10ps
module himl_chk (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // register bus
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  // events and outputs
  input wire [31:0] main_event_src,
  input wire [31:0] tx_last_done,
  input wire [31:0] rx_last_done,
  input wire        irq,
  input wire        iso_transmit_summary,
  input wire        iso_receive_summary
);
  // ==========================================
  // data phase trackers
  reg  wr_dp;
  reg  rd_dp;
  wire take = hsel & hready & htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp <= 1'b0;
      rd_dp <= 1'b0;
    end else begin
      wr_dp <= take & hwrite;
      rd_dp <= take & ~hwrite;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_take; take && !hwrite; endsequence
  sequence s_rd_walk; !hreadyout ##1 hreadyout; endsequence
  property p_rd_wait; s_rd_take |=> s_rd_walk; endproperty
  property p_wr_rdy; take && hwrite |=> hreadyout; endproperty
  property p_resp; hresp == 1'b0; endproperty
  property p_hold; !$stable(hrdata) |-> $past(rd_dp); endproperty
  property p_rst_gate; $rose(hresetn) |-> !irq; endproperty
  property p_tx_sum; !$stable(iso_transmit_summary) |-> $past(wr_dp) || $past(|tx_last_done); endproperty
  property p_rx_sum; !$stable(iso_receive_summary) |-> $past(wr_dp) || $past(|rx_last_done); endproperty
  property p_irq_rise;
    $rose(irq) && $stable(main_event_src) |-> $past(wr_dp) || $past(|tx_last_done) || $past(|rx_last_done);
  endproperty
  property p_irq_fall; $fell(irq) && $stable(main_event_src) |-> $past(wr_dp); endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  a_wr_rdy: assert property (p_wr_rdy) else $error("write stalled");
  a_resp: assert property (p_resp) else $error("response not okay");
  a_hold: assert property (p_hold) else $error("read data changed outside read");
  a_rst_gate: assert property (p_rst_gate) else $error("interrupt after reset");
  a_tx_sum: assert property (p_tx_sum) else $error("tx summary changed alone");
  a_rx_sum: assert property (p_rx_sum) else $error("rx summary changed alone");
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose alone");
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell alone");
endmodule
bind himl_top himl_chk u_chk (.*);

// ==== tb_himl_top.sv ====
// self-checking bench of himl_top over its ahb-lite port
`timescale 1ns/10ps
`include "himl_regs.vh"
module tb_himl_top;
  // ==========================================
  // signals
  reg         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  reg  [1:0]  htrans = 2'h0;
  reg  [31:0] haddr = 32'h0, hwdata = 32'h0, main_event_src = 32'h0, rd;
  reg  [31:0] tx_last_done = 32'h0, rx_last_done = 32'h0, m;
  reg  [63:0] tx_int_ctrl = 64'hC0270, rx_int_ctrl = 64'hC0270;
  wire        hreadyout, hresp, irq, iso_transmit_summary, iso_receive_summary;
  wire [31:0] hrdata;
  integer     n_fail = 0, n_tests = 0, g = 0;
  reg  [11:0] b;
  wire        sum = g[0] ? iso_receive_summary : iso_transmit_summary;
  himl_top dut_u (.hready(hreadyout), .hsize(3'h2), .*);
  initial begin
    forever #10 hclk = ~hclk;
  end
  // ==========================================
  // tasks
  task wrap_up;
    begin
      if (n_fail == 0 && n_tests > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wait_rdy;
    integer k;
    begin
      k = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1 && k < 9) begin
        @(negedge hclk);
        k = k + 1;
      end
      if (hreadyout !== 1'b1) begin
        n_fail = n_fail + 1;
        wrap_up;
      end
      @(posedge hclk);
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (g = 0; g < 2; g = g + 1) begin
      b = 12'h010 << g;
      m = 32'h40 << g;
      bus(1'b1, b + 12'h8, 32'hFFFFFFFF);
      bus(1'b0, b + 12'h8, 32'h0);
      chk(rd, g[0] ? `HIML_RX_IMPL_DEF : `HIML_TX_IMPL_DEF);
      bus(1'b1, b + 12'h4, 32'hFFFFFFFF);
      bus(1'b1, b + 12'hC, 32'hFFFFFFFB);
      tx_last_done <= g ? 32'h0 : 32'h23C;
      rx_last_done <= g ? 32'h23C : 32'h0;
      @(posedge hclk);
      tx_last_done <= 32'h0;
      rx_last_done <= 32'h0;
      bus(1'b0, b, 32'h0);
      chk(rd, 32'h4);
      chk(sum, 1'b1);
      bus(1'b1, b + 12'hC, 32'h4);
      bus(1'b0, b + 12'h4, 32'h0);
      chk(rd, 32'h0);
      chk(sum, 1'b0);
      bus(1'b0, b, 32'h0);
      chk(rd, 32'h4);
      bus(1'b1, b + 12'h8, 32'h4);
      bus(1'b1, `HIML_OFS_MASK_SET, m);
      bus(1'b0, `HIML_OFS_MAIN_EVT_CLR, 32'h0);
      chk(rd, m);
      chk(irq, 1'b0);
      bus(1'b1, `HIML_OFS_MASK_SET, 32'h80000000);
      bus(1'b0, `HIML_OFS_MAIN_EVT_CLR, 32'h0);
      chk(rd, m);
      chk(irq, 1'b1);
      bus(1'b1, `HIML_OFS_MASK_CLR, m);
      bus(1'b0, `HIML_OFS_MASK_SET, 32'h0);
      chk(rd, 32'h80000000);
      chk(irq, 1'b0);
      bus(1'b1, `HIML_OFS_MASK_CLR, 32'h80000000);
      bus(1'b1, b + 12'h4, 32'h4);
      bus(1'b0, b, 32'h0);
      chk(rd, 32'h0);
    end
    bus(1'b1, `HIML_OFS_MASK_SET, 32'hFFFFFFFF);
    bus(1'b0, `HIML_OFS_MASK_CLR, 32'h0);
    chk(rd, `HIML_MAIN_MASK_VALID);
    bus(1'b1, `HIML_OFS_MASK_CLR, 32'h7FFFFFFE);
    main_event_src <= 32'h1;
    bus(1'b0, `HIML_OFS_MAIN_EVT_SET, 32'h0);
    chk(rd, 32'h1);
    chk(irq, 1'b1);
    bus(1'b1, `HIML_OFS_MASK_CLR, 32'h1);
    bus(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `HIML_OFS_MASK_SET, 32'h0);
    chk(rd[31], 1'b0);
    chk(irq, 1'b0);
    wrap_up;
  end
endmodule
